//--- irq_bank_pkg.sv
// Purpose: constants, types and helpers for the radio hardware irq flag bank
// Assumes: 32-bit classic wishbone data, byte offsets as printed
// Notes: flag and enable words share one bit layout
//
// Functional notes
// - read-only 32-bit command status word, reset zero, bus writes ignored.
// - defined flags stay set until software writes zero at 0x08 or one at 0x40; writing one at 0x08 does nothing.
// - flag bits 19..12 hold timer capture/compare channels 7..0 events.
// - bits 11..9 hold engine soft events 2..0; bit 8 engine command complete.
// - flag bit 5 set when the modem finds a sync word.
// - bit 4 modem fifo output, bit 3 fifo input, bit 2 modem done.
// - flag bit 1 holds the synthesizer calibration accelerator event.
// - flag bit 6 holds the debug tracer system tick event.
// - flag bits 31..20, 7 and 0 reserved, read zero; software writes zero.
// - enable register at 0xC, reset zero, same layout, bits 31..20 read-only.
// - each writable enable bit gates the flag at the same position.
package irq_bank_pkg;

  localparam int DATA_W = 32;
  localparam int REG_ADDR_W = 8;
  localparam int NUM_TIMER_CH = 8;
  localparam int NUM_SOFT_EV = 3;

  typedef logic [REG_ADDR_W-1:0] reg_off_t;
  typedef logic [DATA_W-1:0] word_t;

  localparam reg_off_t OFF_COMMAND_STATUS = 8'h04;
  localparam reg_off_t OFF_FLAGS = 8'h08;
  localparam reg_off_t OFF_ENABLE = 8'h0C;
  localparam reg_off_t OFF_FLAG_CLEAR = 8'h40;

  localparam word_t COMMAND_STATUS_RESET = 32'h0000_0000;
  localparam word_t FLAGS_RESET = 32'h0000_0000;
  localparam word_t ENABLE_RESET = 32'h0000_0000;
  localparam word_t FLAG_DEFINED_MASK = 32'h000F_FF7E;
  localparam word_t ENABLE_RW_MASK = 32'h000F_FFFF;
  localparam word_t READ_UNMAPPED = 32'h0000_0000;

  localparam int BIT_TIMER_LO = 12;
  localparam int BIT_SOFT_LO = 9;
  localparam int BIT_ENGINE_DONE = 8;
  localparam int BIT_TRACER_TICK = 6;
  localparam int BIT_SYNC_WORD = 5;
  localparam int BIT_FIFO_OUT = 4;
  localparam int BIT_FIFO_IN = 3;
  localparam int BIT_MODEM_DONE = 2;
  localparam int BIT_SYNTH_CAL = 1;

  // one-cycle event pulses from the radio side; index n is channel n
  typedef struct packed {
    logic [NUM_TIMER_CH-1:0] timer_channel_event;
    logic [NUM_SOFT_EV-1:0] engine_soft_event;
    logic engine_command_complete;
    logic tracer_tick_event;
    logic modem_sync_word_found;
    logic modem_fifo_output_event;
    logic modem_fifo_input_event;
    logic modem_command_complete;
    logic synth_calibration_event;
  } hw_events_t;

  function automatic word_t events_to_word(input hw_events_t e);
    word_t v;
    v = '0;
    v[BIT_TIMER_LO +: NUM_TIMER_CH] = e.timer_channel_event;
    v[BIT_SOFT_LO +: NUM_SOFT_EV] = e.engine_soft_event;
    v[BIT_ENGINE_DONE] = e.engine_command_complete;
    v[BIT_TRACER_TICK] = e.tracer_tick_event;
    v[BIT_SYNC_WORD] = e.modem_sync_word_found;
    v[BIT_FIFO_OUT] = e.modem_fifo_output_event;
    v[BIT_FIFO_IN] = e.modem_fifo_input_event;
    v[BIT_MODEM_DONE] = e.modem_command_complete;
    v[BIT_SYNTH_CAL] = e.synth_calibration_event;
    return v;
  endfunction

  function automatic word_t lanes_to_mask(input logic [DATA_W/8-1:0] sel);
    word_t m;
    m = '0;
    for (int b = 0; b < DATA_W/8; b++) begin
      m[b*8 +: 8] = {8{sel[b]}};
    end
    return m;
  endfunction

endpackage

//--- sticky_flag_bank.sv
// Purpose: per-bit sticky flags, hardware set, software clear
// Assumes: set and clear are single-cycle qualified vectors
// Notes: undefined positions are held at zero
`timescale 1ns/1ps
`default_nettype none
module sticky_flag_bank #(
  parameter int WIDTH = 32,
  parameter logic [WIDTH-1:0] DEFINED_MASK = '1
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // set and clear
  input wire logic [WIDTH-1:0] set_i,
  input wire logic [WIDTH-1:0] clr_i,
  // flag state
  output logic [WIDTH-1:0] flags_o
);

  if (WIDTH < 1) begin : g_bad_width
    $error("sticky_flag_bank needs WIDTH of at least one");
  end

  logic [WIDTH-1:0] next_flags;

  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    // set is or-ed in last so an event landing on a clear survives
    always_comb begin
      next_flags[i] = DEFINED_MASK[i] & ((flags_o[i] & ~clr_i[i]) | set_i[i]);
    end

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        flags_o[i] <= 1'b0;
      end else begin
        flags_o[i] <= next_flags[i];
      end
    end
  end

endmodule
`default_nettype wire

//--- wb_reg_port.sv
// Purpose: classic wishbone slave handshake for a small register file
// Assumes: one access per cycle/strobe pair, no wait states beyond one
// Notes: answers every address; write strobe fires once per access
`timescale 1ns/1ps
`default_nettype none
module wb_reg_port
  import irq_bank_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // bus request
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  // read data from the decoder
  input wire word_t rdata_i,
  // bus answer
  output logic ack_o,
  output word_t dat_o,
  // write strobe
  output logic wr_o
);

  logic access;
  logic next_ack;
  word_t next_dat;

  // ack gating keeps a held request from being taken twice
  always_comb begin
    access = cyc_i & stb_i & ~ack_o;
    next_ack = access;
    next_dat = access ? rdata_i : dat_o;
    wr_o = access & we_i;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= '0;
    end else begin
      ack_o <= next_ack;
      dat_o <= next_dat;
    end
  end

endmodule
`default_nettype wire

//--- radio_hw_irq_flag_bank.sv
// Purpose: command status word, hardware module irq flags and enables
// Assumes: events are synchronous one-cycle pulses on clk_i
// Notes: irq_o lags the flag/enable state by one cycle
//
// The Wishbone slave port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module radio_hw_irq_flag_bank
  import irq_bank_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [DATA_W/8-1:0] sel_i,
  input wire logic [ADDR_W-1:0] adr_i,
  input wire word_t dat_i,
  output word_t dat_o,
  output logic ack_o,
  // radio side events
  input wire hw_events_t events_i,
  // command status source
  input wire word_t cmd_status_i,
  input wire logic cmd_status_load_i,
  // interrupt
  output logic irq_o
);

  if (ADDR_W < REG_ADDR_W) begin : g_bad_addr
    $error("radio_hw_irq_flag_bank needs ADDR_W of at least REG_ADDR_W");
  end

  ////////////////////////////////////////////////////////////////////////
  // address decode

  logic wr;
  logic hi_zero;
  reg_off_t word_adr;
  word_t lane_mask;
  word_t rdata;
  logic hit_status;
  logic hit_flags;
  logic hit_enable;
  logic hit_clear;

  always_comb begin
    // aliases above the map would alias low registers, so demand zeros
    hi_zero = (adr_i >> REG_ADDR_W) == '0;
    word_adr = {adr_i[REG_ADDR_W-1:2], 2'b00};
    lane_mask = lanes_to_mask(sel_i);
    hit_status = hi_zero & (word_adr == OFF_COMMAND_STATUS);
    hit_flags = hi_zero & (word_adr == OFF_FLAGS);
    hit_enable = hi_zero & (word_adr == OFF_ENABLE);
    hit_clear = hi_zero & (word_adr == OFF_FLAG_CLEAR);
  end

  ////////////////////////////////////////////////////////////////////////
  // command status

  word_t command_status;
  word_t next_command_status;

  // bus writes never reach this word
  always_comb begin
    next_command_status = cmd_status_load_i ? cmd_status_i : command_status;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      command_status <= COMMAND_STATUS_RESET;
    end else begin
      command_status <= next_command_status;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // hardware module flags

  word_t hw_module_irq_flags;
  word_t set_vec;
  word_t clr_vec;

  always_comb begin
    set_vec = events_to_word(events_i) & FLAG_DEFINED_MASK;
    clr_vec = '0;
    if (wr && hit_flags) begin
      clr_vec = ~dat_i & lane_mask;
    end else if (wr && hit_clear) begin
      clr_vec = dat_i & lane_mask;
    end
  end

  sticky_flag_bank #(
    .WIDTH(DATA_W),
    .DEFINED_MASK(FLAG_DEFINED_MASK)
  ) u_flags (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .set_i(set_vec),
    .clr_i(clr_vec),
    .flags_o(hw_module_irq_flags)
  );

  ////////////////////////////////////////////////////////////////////////
  // enables

  word_t hw_module_irq_enable;
  word_t next_enable;
  word_t en_wmask;

  always_comb begin
    en_wmask = lane_mask & ENABLE_RW_MASK;
    next_enable = hw_module_irq_enable;
    if (wr && hit_enable) begin
      next_enable = (hw_module_irq_enable & ~en_wmask) | (dat_i & en_wmask);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hw_module_irq_enable <= ENABLE_RESET;
    end else begin
      hw_module_irq_enable <= next_enable;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // interrupt output

  logic next_irq;

  always_comb begin
    next_irq = |(hw_module_irq_flags & hw_module_irq_enable);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= next_irq;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read mux and bus port

  // clear register is write-only and reads zero like a hole
  always_comb begin
    rdata = READ_UNMAPPED;
    if (hit_status) begin
      rdata = command_status;
    end else if (hit_flags) begin
      rdata = hw_module_irq_flags;
    end else if (hit_enable) begin
      rdata = hw_module_irq_enable;
    end
  end

  wb_reg_port u_port (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .cyc_i(cyc_i),
    .stb_i(stb_i),
    .we_i(we_i),
    .rdata_i(rdata),
    .ack_o(ack_o),
    .dat_o(dat_o),
    .wr_o(wr)
  );

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  chk_status_ro_write: assert property (
    (wr && hit_status && !cmd_status_load_i) |=> $stable(command_status)
  ) else $error("command status changed on a bus write");

  chk_status_load: assert property (
    cmd_status_load_i |=> (command_status == $past(cmd_status_i))
  ) else $error("command status missed a load");

  chk_flag_zero_clear: assert property (
    (wr && hit_flags) |=>
      ((hw_module_irq_flags & $past(clr_vec) & ~$past(set_vec)) == '0)
  ) else $error("flag not cleared by a zero write");

  chk_flag_sticky: assert property (
    (clr_vec == '0) |=>
      (($past(hw_module_irq_flags) & ~hw_module_irq_flags) == '0)
  ) else $error("flag dropped without a clear");

  chk_timer_events: assert property (
    (events_i.timer_channel_event != '0) |=>
      ((hw_module_irq_flags[BIT_TIMER_LO +: NUM_TIMER_CH]
        & $past(events_i.timer_channel_event))
        == $past(events_i.timer_channel_event))
  ) else $error("timer channel event not flagged");

  chk_engine_events: assert property (
    (events_i.engine_soft_event != '0 || events_i.engine_command_complete) |=>
      (hw_module_irq_flags[BIT_ENGINE_DONE]
        || !$past(events_i.engine_command_complete)) &&
      ((hw_module_irq_flags[BIT_SOFT_LO +: NUM_SOFT_EV]
        & $past(events_i.engine_soft_event))
        == $past(events_i.engine_soft_event))
  ) else $error("engine event not flagged");

  chk_sync_word: assert property (
    events_i.modem_sync_word_found |=> hw_module_irq_flags[BIT_SYNC_WORD]
  ) else $error("sync word event not flagged");

  chk_modem_events: assert property (
    (events_i.modem_fifo_output_event || events_i.modem_fifo_input_event
      || events_i.modem_command_complete) |=>
      (hw_module_irq_flags[BIT_FIFO_OUT] || !$past(events_i.modem_fifo_output_event))
      && (hw_module_irq_flags[BIT_FIFO_IN] || !$past(events_i.modem_fifo_input_event))
      && (hw_module_irq_flags[BIT_MODEM_DONE] || !$past(events_i.modem_command_complete))
  ) else $error("modem event not flagged");

  chk_synth_event: assert property (
    events_i.synth_calibration_event ##1 !events_i.synth_calibration_event
      |-> hw_module_irq_flags[BIT_SYNTH_CAL]
  ) else $error("calibration event not flagged");

  chk_tracer_tick: assert property (
    $rose(events_i.tracer_tick_event) |=> hw_module_irq_flags[BIT_TRACER_TICK]
  ) else $error("tracer tick not flagged");

  chk_flag_reserved: assert property (
    (hw_module_irq_flags & ~FLAG_DEFINED_MASK) == '0
  ) else $error("reserved flag bit set");

  chk_enable_reserved: assert property (
    (hw_module_irq_enable & ~ENABLE_RW_MASK) == '0
  ) else $error("read-only enable bit set");

  chk_enable_write: assert property (
    (wr && hit_enable) |=>
      ((hw_module_irq_enable & $past(en_wmask)) == ($past(dat_i) & $past(en_wmask)))
  ) else $error("enable write not stored");

  chk_irq_gate: assert property (
    ##1 (irq_o == |($past(hw_module_irq_flags) & $past(hw_module_irq_enable)))
  ) else $error("interrupt does not follow flags and enables");

  chk_set_beats_clear: assert property (
    ((set_vec & clr_vec) != '0) |=>
      ((hw_module_irq_flags & $past(set_vec) & $past(clr_vec))
        == ($past(set_vec) & $past(clr_vec)))
  ) else $error("clear beat a same-cycle set");

  chk_ack_pulse: assert property (
    ack_o |=> !ack_o
  ) else $error("ack held longer than one cycle");

  chk_clear_reg_w1c: assert property (
    (wr && hit_clear) |=>
      ((hw_module_irq_flags & $past(dat_i) & $past(lane_mask) & ~$past(set_vec)) == '0)
  ) else $error("flag not cleared by the clear register");

  chk_flag_no_rise: assert property (
    (set_vec == '0) |=>
      ((hw_module_irq_flags & ~$past(hw_module_irq_flags)) == '0)
  ) else $error("flag rose without an event");

  chk_flag_write_one: assert property (
    (wr && hit_flags && set_vec == '0) |=>
      ((hw_module_irq_flags & $past(dat_i) & $past(lane_mask))
        == ($past(hw_module_irq_flags) & $past(dat_i) & $past(lane_mask)))
  ) else $error("writing one changed a flag");

  chk_enable_hold: assert property (
    !(wr && hit_enable) |=> $stable(hw_module_irq_enable)
  ) else $error("enable changed without a write");

  chk_irq_when_set: assert property (
    ((hw_module_irq_flags & hw_module_irq_enable) != '0) |=> irq_o
  ) else $error("interrupt low with an enabled flag set");

  chk_irq_when_clear: assert property (
    ((hw_module_irq_flags & hw_module_irq_enable) == '0) |=> !irq_o
  ) else $error("interrupt high with no enabled flag set");

  chk_ack_answer: assert property (
    (cyc_i && stb_i && !ack_o) |=> ack_o
  ) else $error("request not acknowledged in one cycle");

  chk_status_read: assert property (
    (cyc_i && stb_i && !ack_o && !we_i && hit_status) |=>
      (dat_o == $past(command_status))
  ) else $error("command status read returned wrong data");

  chk_status_hold: assert property (
    !cmd_status_load_i |=> $stable(command_status)
  ) else $error("command status changed without a load");

endmodule
`default_nettype wire

//--- radio_event_source.sv
// Purpose: radio side event source driving the flag bank
// Assumes: the bench asks for a pulse one cycle ahead
// Notes: each request is replayed as a one-cycle pulse
`timescale 1ns/1ps
`default_nettype none
module radio_event_source
  import irq_bank_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // pulse request
  input wire hw_events_t req_i,
  // events to the bank
  output hw_events_t events_o
);
  hw_events_t next_events;
  // registered so a pulse never shares a cycle with its request
  always_comb begin
    next_events = rst_i ? '0 : req_i;
  end
  always_ff @(posedge clk_i) begin
    events_o <= next_events;
  end
endmodule
`default_nettype wire

//--- test_radio_hw_irq_flag_bank.sv
// Purpose: self-checking bench for the radio hardware irq flag bank
// Assumes: one-cycle ack, registered irq with one cycle lag
// Notes: random clears and enables from a fixed xorshift seed
`timescale 1ns/1ps
`default_nettype none
module test_radio_hw_irq_flag_bank;
  import irq_bank_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [3:0] sel = 4'h0;
  logic [7:0] adr = 8'h00;
  word_t dat = 32'h0000_0000;
  word_t cmd = 32'h0000_0000;
  logic load = 1'b0;
  hw_events_t req = '0;
  hw_events_t events;
  word_t dat_o;
  logic ack_o;
  logic irq_o;
  word_t flags, en, rd, d, m, r;
  logic [31:0] seed;
  int n_fail = 0;
  int tests_run = 0;

  always #5 clk_i = ~clk_i;

  radio_hw_irq_flag_bank #(.ADDR_W(8)) i_radio_hw_irq_flag_bank (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc), .stb_i(stb), .we_i(we), .sel_i(sel), .adr_i(adr), .dat_i(dat),
    .dat_o(dat_o), .ack_o(ack_o), .events_i(events), .cmd_status_i(cmd),
    .cmd_status_load_i(load), .irq_o(irq_o));
  radio_event_source i_radio_event_source (.clk_i(clk_i), .rst_i(rst_i), .req_i(req),
    .events_o(events));

  ////////////////////////////////////////////////////////////////////////////
  function automatic word_t rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // struct lsb first: six modem/tracer/synth bits, then a hole at 7
  function automatic word_t map_ev(input logic [17:0] v);
    word_t w;
    w = '0;
    for (int k = 0; k < 18; k++) begin
      w[k < 6 ? k + 1 : k + 2] = v[k];
    end
    return w;
  endfunction
  function automatic word_t lanes(input logic [3:0] s);
    return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    if (n_fail == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk_word(input word_t got, input word_t exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t word got %h want %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t irq got %b want %b", $time, got, exp);
    end
  endtask
  // also drops any pending event request at its first edge
  task automatic wb(input logic w, input logic [7:0] a, input word_t dw, input logic [3:0] s);
    int n;
    @(posedge clk_i);
    req <= '0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= dw;
    sel <= s;
    n = 0;
    // ack and read data are taken at the rising edge that samples ack high
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    if (n >= 50) begin
      n_fail++;
      $display("[FAIL] %0t bus timeout", $time);
      complete_run();
    end else begin
      rd = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input word_t exp);
    wb(1'b0, a, 32'h0000_0000, 4'hF);
    chk_word(rd, exp);
  endtask
  task automatic pulse(input logic [17:0] v);
    @(posedge clk_i);
    req <= hw_events_t'(v);
    @(posedge clk_i);
    req <= '0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 32'h0000_A857;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk(8'h04, 32'h0000_0000);
    rd_chk(8'h08, 32'h0000_0000);
    rd_chk(8'h0C, 32'h0000_0000);
    wb(1'b1, 8'h20, 32'hFFFF_FFFF, 4'hF);
    rd_chk(8'h20, 32'h0000_0000);
    rd_chk(8'h40, 32'h0000_0000);
    @(posedge clk_i);
    cmd <= 32'hA5C3_0F1E;
    load <= 1'b1;
    @(posedge clk_i);
    load <= 1'b0;
    rd_chk(8'h04, 32'hA5C3_0F1E);
    wb(1'b1, 8'h04, 32'h5A3C_F0E1, 4'hF);
    rd_chk(8'h04, 32'hA5C3_0F1E);
    wb(1'b1, 8'h0C, 32'hFFFF_FFFF, 4'hF);
    rd_chk(8'h0C, 32'h000F_FFFF);
    wb(1'b1, 8'h0C, 32'h0000_0000, 4'hF);
    pulse(18'h3FFFF);
    rd_chk(8'h08, 32'h000F_FF7E);
    chk_bit(irq_o, 1'b0);
    for (int k = 0; k < 18; k++) begin
      wb(1'b1, 8'h08, 32'h0000_0000, 4'hF);
      pulse(18'h00001 << k);
      rd_chk(8'h08, map_ev(18'h00001 << k));
      wb(1'b1, 8'h08, 32'h000F_FF7E, 4'hF);
      rd_chk(8'h08, map_ev(18'h00001 << k));
    end
    wb(1'b1, 8'h08, 32'h0000_0000, 4'hF);
    // event lands on the very edge that takes the clearing write
    @(posedge clk_i);
    req <= hw_events_t'(18'h00001);
    wb(1'b1, 8'h08, 32'h0000_0000, 4'hF);
    rd_chk(8'h08, 32'h0000_0002);
    flags = 32'h0000_0002;
    en = 32'h0000_0000;
    for (int i = 0; i < 60; i++) begin
      d = rnd();
      pulse(d[17:0]);
      flags |= map_ev(d[17:0]);
      rd_chk(8'h08, flags);
      // lanes and target come from the raw word; data keeps reserved bits zero
      r = rnd();
      d = r & 32'h000F_FF7E;
      m = lanes(r[23:20]);
      if (r[0]) begin
        wb(1'b1, 8'h40, d, r[23:20]);
        flags &= ~(d & m);
      end else begin
        wb(1'b1, 8'h08, d, r[23:20]);
        flags &= d | ~m;
      end
      d = rnd();
      m = lanes(d[31:28]);
      wb(1'b1, 8'h0C, d, d[31:28]);
      en = (en & ~m) | (d & m & 32'h000F_FFFF);
      rd_chk(8'h0C, en);
      chk_bit(irq_o, |(flags & en));
    end
    complete_run();
  end
endmodule
`default_nettype wire
